//--- inc/ecp_pkg.sv
// ecp parallel port mode control: shared constants and types
package ecp_pkg;
  // ----------------------------------------
  // register map (byte offsets from port base)
  // ----------------------------------------
  localparam logic [10:0] ECP_OFS_DATA = 11'h000;
  localparam logic [10:0] ECP_OFS_DCR = 11'h002;
  localparam logic [10:0] ECP_OFS_DSR = 11'h001;
  localparam logic [10:0] ECP_OFS_FIFO = 11'h400;
  localparam logic [10:0] ECP_OFS_CFGB = 11'h401;
  localparam logic [10:0] ECP_OFS_XCR = 11'h402;
  localparam logic [10:0] ECP_OFS_OPT = 11'h403;
  // ----------------------------------------
  // mode codes
  // ----------------------------------------
  localparam logic [2:0] ECP_M_STD = 3'h0;
  localparam logic [2:0] ECP_M_BIDI = 3'h1;
  localparam logic [2:0] ECP_M_PFIFO = 3'h2;
  localparam logic [2:0] ECP_M_ECP = 3'h3;
  localparam logic [2:0] ECP_M_EPP = 3'h4;
  localparam logic [2:0] ECP_M_TEST = 3'h6;
  localparam logic [2:0] ECP_M_CFG = 3'h7;
  // ----------------------------------------
  // field positions and values
  // ----------------------------------------
  localparam int ECP_XCR_MODE_LSB = 5;
  localparam int ECP_XCR_FULL = 1;
  localparam int ECP_XCR_EMPTY = 0;
  localparam int ECP_DCR_STB = 0;
  localparam int ECP_DCR_AFD = 1;
  localparam int ECP_DCR_INIT = 2;
  localparam int ECP_DCR_SEL = 3;
  localparam int ECP_DCR_DIR = 5;
  localparam logic [7:0] ECP_CFGA_VAL = 8'h10;
  localparam logic [7:0] ECP_DCR_RST = 8'h00;
  localparam logic [7:0] ECP_XCR_RST = 8'h00;
  localparam logic [5:0] ECP_DCR_WMASK = 6'h3F;
  // strobe pulse width in ns, rounded up to cycles of the 100 MHz clock
  localparam int ECP_STB_NS = 500;
  localparam int ECP_STB_CYC = (ECP_STB_NS + 9) / 10;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef struct packed {
    logic tag_cmd;
    logic [7:0] data;
  } ecp_entry_t;
  typedef struct packed {
    logic [10:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ecp_bus_t;
  typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_WAIT_BUSY, ST_STB, ST_WAIT_REL, ST_REV_ACK} ecp_state_t;
endpackage

//--- hdl/ecp_fifo_mem.sv
// ecp parallel port: small byte queue with registered read data
`timescale 1ns/1ps
module ecp_fifo_mem import ecp_pkg::*; #(
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // control
  input wire logic flush,
  input wire logic push,
  input wire ecp_entry_t push_data,
  input wire logic pop,
  // status and data
  output ecp_entry_t head,
  output logic full,
  output logic empty
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("depth must be a power of two");
  end
  ecp_entry_t mem_r [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic do_push;
  logic do_pop;
  assign full = (cnt_r == (AW+1)'(DEPTH));
  assign empty = (cnt_r == '0);
  assign do_push = push && !full;
  assign do_pop = pop && !empty;
  always_ff @(posedge clock) begin
    if (do_push) begin
      mem_r[wp_r] <= push_data;
    end
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else if (flush) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (do_push) wp_r <= wp_r + 1'b1;
      if (do_pop) rp_r <= rp_r + 1'b1;
      cnt_r <= cnt_r + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end
  // head is registered; empty read repeats last byte
  // a push into an empty queue lands here at once, so head is never stale
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      head <= '0;
    end else if (do_push && (empty || (do_pop && cnt_r == (AW+1)'(1)))) begin
      head <= push_data;
    end else if (do_pop && cnt_r > (AW+1)'(1)) begin
      head <= mem_r[rp_r + 1'b1];
    end
  end
endmodule // ecp_fifo_mem

//--- hdl/ecp_port.sv
// ecp parallel port mode control and fifo data phase
//
// Contract
// R1: full bit set when fifo cannot take a byte, empty bit when none.
// R2: standard mode holds fifo reset, control outputs open-collector, direction ignored.
// R3: bidirectional mode: direction tri-states data, data read returns pins, push-pull.
// R4: parallel fifo mode sends fifo bytes with compatibility handshake, forward only.
// R5: ecp forward merges data and command writes into one queue, sent in order.
// R6: ecp reverse receives peripheral bytes into the fifo for host reads.
// R7: mode 100 is epp only when option enabled; 101 reserved; push-pull.
// R8: test mode allows free fifo access with no port handshake.
// R9: configuration mode maps config a and b at 0x400 and 0x401.
// R10: config b bits 5:3 encode the selected interrupt line.
// R11: config b bits 2:0 encode the selected dma channel.
// R12: automatic handshaking only in modes 010 and 011.
// R13: from 000/001 any mode; otherwise only back to 000 or 001.
// R14: direction changes only in mode 001.
// R15: leaving forward extended mode deasserts all control signals first.
// R16: leaving ecp reverse deasserts host acknowledge at once, drops surplus bytes.
// R17: handshake outputs are registered and glitch-free over mode changes.
// R18: host sets direction, strobe, autofeed to 0 before entering ecp mode.
// R19: reverse ecp keeps handshaking bytes while fifo has room.
// R20: command bytes byte-wide and forward only; all transfers byte-wide.
// R21: forward host ack high for data, low for commands.
// R22: peripheral marks reverse data by periph ack high, commands low.
// R23: extended control bits 7:5 hold the read/write mode code.
// R24: direction ignored in 000 and 010; elsewhere 0 output, 1 input.
`timescale 1ns/1ps
module ecp_port import ecp_pkg::*; #(
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // register port
  input wire logic [10:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // chip configuration
  input wire logic epp_option,
  input wire logic [3:0] irq_sel,
  input wire logic [1:0] dma_sel,
  input wire logic irq_level,
  // cable data
  input wire logic [7:0] pd_in,
  output logic [7:0] pd_out,
  output logic pd_oe,
  // cable control outputs (open-collector in mode 000)
  output logic strobe_out_low,
  output logic strobe_oe,
  output logic autofeed_out_low,
  output logic autofeed_oe,
  output logic init_out_low,
  output logic init_oe,
  output logic select_in_out_low,
  output logic select_in_oe,
  // cable status inputs
  input wire logic busy_in,
  input wire logic ack_in_low,
  input wire logic fault_in_low,
  input wire logic select_in,
  input wire logic perror_in,
  // status
  output logic epp_active
);
  initial begin
    if (DEPTH < 2) $error("fifo depth too small");
  end
  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [2:0] mode_r;
  logic [5:0] dcr_r;
  logic [4:0] xcr_lo_r;
  logic [7:0] data_r;
  ecp_state_t st_r;
  logic [7:0] cnt_r;
  logic [7:0] out_r;
  logic hostack_r;
  logic stb_r;
  logic afd_r;
  logic fwd_rdy;
  logic fifo_full;
  logic fifo_empty;
  logic fifo_push;
  logic fifo_pop;
  logic fifo_flush;
  ecp_entry_t fifo_in;
  ecp_entry_t fifo_head;
  logic dir;
  logic auto_hs;
  logic fifo_win;
  logic [2:0] cfgb_irq;
  logic [2:0] cfgb_dma;
  logic mode_wr;
  logic [2:0] mode_nxt;
  logic mode_ok;
  logic stb_end;
  // direction only meaningful outside 000 and 010
  assign dir = dcr_r[ECP_DCR_DIR] && mode_r != ECP_M_STD && mode_r != ECP_M_PFIFO; // R24
  assign auto_hs = mode_r == ECP_M_PFIFO || mode_r == ECP_M_ECP; // R12
  assign fifo_win = mode_r == ECP_M_PFIFO || mode_r == ECP_M_ECP || mode_r == ECP_M_TEST;
  assign epp_active = mode_r == ECP_M_EPP && epp_option; // R7
  // ----------------------------------------
  // mode register writes
  // ----------------------------------------
  assign mode_wr = wr && addr == ECP_OFS_XCR;
  assign mode_nxt = wdata[ECP_XCR_MODE_LSB +: 3];
  assign mode_ok = mode_r == ECP_M_STD || mode_r == ECP_M_BIDI ||
                   mode_nxt == ECP_M_STD || mode_nxt == ECP_M_BIDI; // R13
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode_r <= ECP_XCR_RST[7:5];
      xcr_lo_r <= ECP_XCR_RST[4:0];
    end else if (mode_wr) begin
      if (mode_ok) mode_r <= mode_nxt; // R23
      xcr_lo_r <= {wdata[4:2], 2'b00};
    end
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dcr_r <= ECP_DCR_RST[5:0];
    end else if (wr && addr == ECP_OFS_DCR) begin
      dcr_r[4:0] <= wdata[4:0] & ECP_DCR_WMASK[4:0];
      if (mode_r == ECP_M_BIDI) dcr_r[ECP_DCR_DIR] <= wdata[ECP_DCR_DIR]; // R14
    end
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      data_r <= '0;
    end else if (wr && addr == ECP_OFS_DATA && (mode_r == ECP_M_STD || mode_r == ECP_M_BIDI)) begin
      data_r <= wdata;
    end
  end
  // ----------------------------------------
  // fifo
  // ----------------------------------------
  assign fifo_flush = mode_r == ECP_M_STD || mode_r == ECP_M_BIDI; // R2 R16
  always_comb begin
    fifo_push = 1'b0;
    fifo_in = '0;
    if (wr && addr == ECP_OFS_FIFO && fifo_win && !(mode_r == ECP_M_ECP && dir)) begin
      fifo_push = 1'b1; // R4 R5 R8
      fifo_in = '{tag_cmd: 1'b0, data: wdata};
    end else if (wr && addr == ECP_OFS_DATA && mode_r == ECP_M_ECP && !dir) begin
      fifo_push = 1'b1; // R5 R20
      fifo_in = '{tag_cmd: 1'b1, data: wdata};
    end else if (st_r == ST_REV_ACK && !ack_in_low && afd_r) begin
      // byte taken at the peripheral strobe; busy low marks a reverse command
      fifo_push = 1'b1; // R6 R19
      fifo_in = '{tag_cmd: !busy_in, data: pd_in};
    end
  end
  assign fifo_pop = (rd && addr == ECP_OFS_FIFO && (mode_r == ECP_M_TEST || (mode_r == ECP_M_ECP && dir)))
                    || (st_r == ST_WAIT_REL && auto_hs && !dir);
  ecp_fifo_mem #(.DEPTH(DEPTH)) u_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .flush(fifo_flush),
    .push(fifo_push),
    .push_data(fifo_in),
    .pop(fifo_pop),
    .head(fifo_head),
    .full(fifo_full),
    .empty(fifo_empty)
  );
  // ----------------------------------------
  // automatic handshake engine
  // ----------------------------------------
  assign fwd_rdy = auto_hs && !dir && !fifo_empty;
  assign stb_end = cnt_r == 8'(ECP_STB_CYC);
  // reverse leg: host ack low requests a byte, peripheral ack (busy) marks data
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= ST_IDLE;
      cnt_r <= '0;
      out_r <= '0;
      hostack_r <= 1'b1;
      stb_r <= 1'b0;
      afd_r <= 1'b0;
    end else if (!auto_hs) begin
      // all engine-driven controls return to rest at once
      st_r <= ST_IDLE; // R15 R16
      stb_r <= 1'b0;
      afd_r <= 1'b0;
      hostack_r <= 1'b1;
      cnt_r <= '0;
    end else begin
      case (st_r)
        ST_IDLE: begin
          cnt_r <= '0;
          if (fwd_rdy && !busy_in) begin
            out_r <= fifo_head.data;
            hostack_r <= !(mode_r == ECP_M_ECP && fifo_head.tag_cmd); // R21
            st_r <= ST_SETUP;
          end else if (mode_r == ECP_M_ECP && dir && !fifo_full) begin
            afd_r <= 1'b1; // R6 R19
            st_r <= ST_REV_ACK;
          end
        end
        ST_SETUP: begin
          stb_r <= 1'b1; // R4
          st_r <= ST_STB;
        end
        ST_STB: begin
          cnt_r <= cnt_r + 8'h01;
          if (stb_end) begin
            stb_r <= 1'b0;
            st_r <= ST_WAIT_REL;
          end
        end
        ST_WAIT_REL: begin
          cnt_r <= '0;
          st_r <= ST_WAIT_BUSY;
        end
        ST_WAIT_BUSY: begin
          if (!busy_in) st_r <= ST_IDLE;
        end
        ST_REV_ACK: begin
          // byte taken on peripheral strobe; release and await its release
          if (!ack_in_low && afd_r) afd_r <= 1'b0;
          if (ack_in_low && !afd_r) st_r <= ST_IDLE;
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end
  // ----------------------------------------
  // pins
  // ----------------------------------------
  always_comb begin
    pd_out = auto_hs ? out_r : data_r;
    pd_oe = !dir; // R3 R24
    strobe_out_low = !(dcr_r[ECP_DCR_STB] || stb_r); // R17
    autofeed_out_low = !(auto_hs ? (mode_r == ECP_M_ECP && dir ? afd_r : !hostack_r) : dcr_r[ECP_DCR_AFD]); // R21
    init_out_low = dcr_r[ECP_DCR_INIT];
    select_in_out_low = !dcr_r[ECP_DCR_SEL];
    // open-collector: drive only the low level in standard mode
    strobe_oe = mode_r != ECP_M_STD || !strobe_out_low; // R2
    autofeed_oe = mode_r != ECP_M_STD || !autofeed_out_low; // R2
    init_oe = mode_r != ECP_M_STD || !init_out_low; // R2
    select_in_oe = mode_r != ECP_M_STD || !select_in_out_low; // R2
  end
  // ----------------------------------------
  // config b encodings
  // ----------------------------------------
  always_comb begin
    case (irq_sel) // R10
      4'hF: cfgb_irq = 3'h6;
      4'hE: cfgb_irq = 3'h5;
      4'hB: cfgb_irq = 3'h4;
      4'hA: cfgb_irq = 3'h3;
      4'h9: cfgb_irq = 3'h2;
      4'h7: cfgb_irq = 3'h1;
      4'h5: cfgb_irq = 3'h7;
      default: cfgb_irq = 3'h0;
    endcase
    case (dma_sel) // R11
      2'h3: cfgb_dma = 3'h3;
      2'h2: cfgb_dma = 3'h2;
      2'h1: cfgb_dma = 3'h1;
      default: cfgb_dma = 3'h0;
    endcase
  end
  // ----------------------------------------
  // read data, one cycle after the strobe
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= '0;
    end else if (rd) begin
      case (addr)
        ECP_OFS_DATA: rdata <= (mode_r == ECP_M_BIDI) ? pd_in : data_r; // R3
        ECP_OFS_DSR: rdata <= {!busy_in, ack_in_low, perror_in, select_in, fault_in_low, 3'h0};
        ECP_OFS_DCR: rdata <= {2'b00, dcr_r};
        ECP_OFS_FIFO: rdata <= (mode_r == ECP_M_CFG) ? ECP_CFGA_VAL : fifo_head.data; // R9
        ECP_OFS_CFGB: rdata <= (mode_r == ECP_M_CFG) ? {1'b0, irq_level, cfgb_irq, cfgb_dma} : 8'h00; // R9
        ECP_OFS_XCR: rdata <= {mode_r, xcr_lo_r[4:2], fifo_full, fifo_empty}; // R1 R23
        ECP_OFS_OPT: rdata <= {7'h00, epp_option};
        default: rdata <= 8'h00;
      endcase
    end else begin
      rdata <= '0;
    end
  end
  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_mode_illegal: assert property (@(posedge clock) disable iff (!rst_n) // R13
    (mode_r != ECP_M_STD && mode_r != ECP_M_BIDI && mode_wr && !mode_ok) |=> $stable(mode_r))
    else $error("illegal mode transition taken");
  chk_dir_locked: assert property (@(posedge clock) disable iff (!rst_n) // R14
    (mode_r != ECP_M_BIDI) |=> $stable(dcr_r[ECP_DCR_DIR]))
    else $error("direction changed outside mode 001");
  chk_stb_quiet: assert property (@(posedge clock) disable iff (!rst_n) // R12
    !auto_hs |=> !stb_r)
    else $error("engine strobe outside fifo modes");
  chk_hostack_rel: assert property (@(posedge clock) disable iff (!rst_n) // R16
    ($past(auto_hs) && !auto_hs) |-> ##1 (hostack_r && !afd_r))
    else $error("host ack not released on mode exit");
  chk_fifo_flush: assert property (@(posedge clock) disable iff (!rst_n) // R2
    (mode_r == ECP_M_STD) |=> fifo_empty)
    else $error("fifo not held in reset in standard mode");
  chk_oc_std: assert property (@(posedge clock) disable iff (!rst_n) // R2
    (mode_r == ECP_M_STD && strobe_out_low) |-> !strobe_oe)
    else $error("strobe driven high in standard mode");
  chk_cmd_ack: assert property (@(posedge clock) disable iff (!rst_n) // R21
    (st_r == ST_IDLE && fwd_rdy && !busy_in && mode_r == ECP_M_ECP) |=> (hostack_r == !$past(fifo_head.tag_cmd)))
    else $error("host ack does not mark command");
  chk_rdata_flags: assert property (@(posedge clock) disable iff (!rst_n) // R1
    (rd && addr == ECP_OFS_XCR) |=> (rdata[ECP_XCR_EMPTY] == $past(fifo_empty) && rdata[ECP_XCR_FULL] == $past(fifo_full)))
    else $error("fifo flags read back wrong");
endmodule // ecp_port

//--- dv/ecp_printer_model.sv
// ecp parallel port: behavioural peripheral on the cable side
`timescale 1ns/1ps
module ecp_printer_model (
  // clock
  input wire logic clock,
  // lines as seen at the connector
  input wire logic strobe_line,
  input wire logic autofeed_line,
  input wire logic [7:0] pd_out,
  input wire logic pd_oe,
  // peripheral drives
  output logic [7:0] pd_in,
  output logic busy_in,
  output logic ack_in_low
);
  // captured forward units {host ack level, byte}; bytes queued for reverse
  logic [8:0] fwd_q[$];
  logic [7:0] rev_q[$];
  int dly = 1;
  logic [7:0] cur;
  // ----------------------------------------
  // handshake engine
  // ----------------------------------------
  initial begin
    pd_in = 8'hA5;
    busy_in = 1'b0;
    ack_in_low = 1'b1;
    forever begin
      @(posedge clock);
      if (!strobe_line && pd_oe) begin
        fwd_q.push_back({autofeed_line, pd_out});
        busy_in <= 1'b1;
        while (!strobe_line) @(posedge clock);
        repeat (dly) @(posedge clock);
        busy_in <= 1'b0;
      end else if (!autofeed_line && !pd_oe && rev_q.size() > 0) begin
        cur = rev_q.pop_front();
        pd_in <= cur;
        busy_in <= 1'b1;
        repeat (dly) @(posedge clock);
        ack_in_low <= 1'b0;
        // host may abort mid-byte: release follows its ack either way
        do @(posedge clock); while (!autofeed_line);
        ack_in_low <= 1'b1;
        busy_in <= 1'b0;
        // released lines must not keep the old byte
        pd_in <= ~cur;
      end
    end
  end
endmodule // ecp_printer_model

//--- dv/ecp_parallel_port_mode_control_test.sv
// ecp parallel port: self-checking bench with printer model
`timescale 1ns/1ps
module ecp_parallel_port_mode_control_test import ecp_pkg::*;;
  localparam int DEPTH = 8;
  localparam int LIM = 4000;
  logic clock, rst_n, wr, rd, epp_option, irq_level, fault_in_low, select_in, perror_in;
  logic [10:0] addr;
  logic [7:0] wdata, rdata, pd_out, pd_in, v, b;
  logic [3:0] irq_sel;
  logic [1:0] dma_sel;
  logic pd_oe, strobe_out_low, strobe_oe, autofeed_out_low, autofeed_oe, init_out_low, init_oe;
  logic select_in_out_low, select_in_oe, epp_active, busy_in, ack_in_low, strobe_line, autofeed_line;
  logic [31:0] seed = 32'h00011019;
  logic [8:0] exp_q[$];
  logic [8:0] got;
  int num_errors, n_checks, k;
  // open-collector lines float high through the cable pull-ups
  assign strobe_line = strobe_oe ? strobe_out_low : 1'b1;
  assign autofeed_line = autofeed_oe ? autofeed_out_low : 1'b1;
  ecp_port #(.DEPTH(DEPTH)) i_ecp_port (.clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .epp_option(epp_option), .irq_sel(irq_sel), .dma_sel(dma_sel), .irq_level(irq_level),
    .pd_in(pd_in), .pd_out(pd_out), .pd_oe(pd_oe), .strobe_out_low(strobe_out_low), .strobe_oe(strobe_oe),
    .autofeed_out_low(autofeed_out_low), .autofeed_oe(autofeed_oe), .init_out_low(init_out_low), .init_oe(init_oe),
    .select_in_out_low(select_in_out_low), .select_in_oe(select_in_oe), .busy_in(busy_in), .ack_in_low(ack_in_low),
    .fault_in_low(fault_in_low), .select_in(select_in), .perror_in(perror_in), .epp_active(epp_active));
  ecp_printer_model i_ecp_printer_model (.clock(clock), .strobe_line(strobe_line), .autofeed_line(autofeed_line),
    .pd_out(pd_out), .pd_oe(pd_oe), .pd_in(pd_in), .busy_in(busy_in), .ack_in_low(ack_in_low));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [2:0] irq_code(input logic [3:0] n);
    case (n)
      4'hF: return 3'h6;
      4'hE: return 3'h5;
      4'hB: return 3'h4;
      4'hA: return 3'h3;
      4'h9: return 3'h2;
      4'h7: return 3'h1;
      4'h5: return 3'h7;
      default: return 3'h0;
    endcase
  endfunction
  task automatic conclude();
    if (num_errors == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wreg(input logic [10:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [10:0] a);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    @(negedge clock);
    v = rdata;
  endtask
  task automatic set_mode(input logic [2:0] m);
    wreg(ECP_OFS_XCR, {m, 5'h00});
  endtask
  task automatic settle();
    repeat (2) @(negedge clock);
  endtask
  task automatic wait_empty();
    for (k = 0; k < LIM; k++) begin
      rreg(ECP_OFS_XCR);
      if (v[ECP_XCR_EMPTY] === 1'b1) break;
    end
    if (k == LIM) begin
      num_errors++;
      conclude();
    end
  endtask
  task automatic wait_fwd(input int n);
    for (k = 0; k < LIM; k++) begin
      @(posedge clock);
      if (i_ecp_printer_model.fwd_q.size() >= n) break;
    end
    if (k == LIM) begin
      num_errors++;
      conclude();
    end
  endtask
  // ----------------------------------------
  // clock and main sequence
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    rst_n = 1'b0;
    {wr, rd, epp_option, irq_level, select_in, perror_in} = 6'h00;
    fault_in_low = 1'b1;
    addr = 11'h000;
    wdata = 8'h00;
    irq_sel = 4'h0;
    dma_sel = 2'h0;
    num_errors = 0;
    n_checks = 0;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    // standard mode: fifo held empty, open-collector, direction ignored
    rreg(ECP_OFS_XCR);
    chk(v & 8'hE3, 8'h01);
    chk(strobe_oe, 1'b0);
    chk({init_oe, select_in_oe}, 2'h2);
    wreg(ECP_OFS_DCR, 8'h21);
    settle();
    chk(strobe_line, 1'b0);
    chk(pd_oe, 1'b1);
    wreg(ECP_OFS_DCR, 8'h00);
    settle();
    i_ecp_printer_model.fwd_q.delete();
    // mode table: codes 010 to 111 entered from 000, illegal hop refused
    @(posedge clock);
    epp_option <= 1'b1;
    for (int m = 2; m < 8; m++) begin
      set_mode(m[2:0]);
      rreg(ECP_OFS_XCR);
      chk(v[7:5], m[2:0]);
      chk(epp_active, m == 4);
      set_mode(m == 6 ? ECP_M_ECP : ECP_M_TEST);
      rreg(ECP_OFS_XCR);
      chk(v[7:5], m[2:0]);
      set_mode(ECP_M_STD);
      rreg(ECP_OFS_XCR);
      chk(v[7:5], 3'h0);
    end
    @(posedge clock);
    epp_option <= 1'b0;
    set_mode(ECP_M_EPP);
    settle();
    chk(epp_active, 1'b0);
    set_mode(ECP_M_STD);
    // configuration mode: both read-only registers, every irq select
    set_mode(ECP_M_CFG);
    rreg(ECP_OFS_FIFO);
    chk(v, 8'h10);
    for (int n = 0; n < 16; n++) begin
      @(posedge clock);
      irq_sel <= n[3:0];
      {dma_sel, irq_level, fault_in_low, select_in, perror_in} <= 6'(rnd());
      rreg(ECP_OFS_CFGB);
      chk(v[5:3], irq_code(n[3:0]));
      chk(v[2:0], {1'b0, dma_sel});
    end
    set_mode(ECP_M_STD);
    // test mode: fill until full, nothing leaves on the cable
    set_mode(ECP_M_TEST);
    for (k = 0; k < 40; k++) begin
      rreg(ECP_OFS_XCR);
      if (v[ECP_XCR_FULL] === 1'b1) break;
      b = 8'(rnd());
      wreg(ECP_OFS_FIFO, b);
      exp_q.push_back({1'b0, b});
    end
    chk(9'(k), 9'(DEPTH));
    chk(i_ecp_printer_model.fwd_q.size() == 0, 1'b1);
    for (int i = 0; i < DEPTH; i++) begin
      rreg(ECP_OFS_FIFO);
      chk(v, exp_q.pop_front());
    end
    rreg(ECP_OFS_XCR);
    chk(v[ECP_XCR_EMPTY], 1'b1);
    rreg(ECP_OFS_FIFO);
    chk(v, b);
    set_mode(ECP_M_STD);
    // parallel fifo mode: one byte with the compatibility handshake
    set_mode(ECP_M_PFIFO);
    b = 8'(rnd());
    wreg(ECP_OFS_FIFO, b);
    wait_fwd(1);
    got = i_ecp_printer_model.fwd_q.pop_front();
    chk(got[7:0], b);
    wait_empty();
    set_mode(ECP_M_STD);
    // bidirectional: input direction floats data, data port reads pins
    set_mode(ECP_M_BIDI);
    wreg(ECP_OFS_DCR, 8'h20);
    settle();
    chk(pd_oe, 1'b0);
    chk(strobe_oe, 1'b1);
    rreg(ECP_OFS_DATA);
    chk(v, pd_in);
    wreg(ECP_OFS_DCR, 8'h00);
    set_mode(ECP_M_ECP);
    // ecp forward: commands and data interleaved in one queue
    for (int i = 0; i < 6; i++) begin
      b = 8'(rnd());
      if (rnd() & 32'h1) begin
        wreg(ECP_OFS_DATA, b);
        exp_q.push_back({1'b0, b});
      end else begin
        wreg(ECP_OFS_FIFO, b);
        exp_q.push_back({1'b1, b});
      end
    end
    wait_fwd(6);
    for (int i = 0; i < 6; i++) begin
      chk(i_ecp_printer_model.fwd_q.pop_front(), exp_q.pop_front());
    end
    wait_empty();
    wreg(ECP_OFS_DCR, 8'h20);
    rreg(ECP_OFS_DCR);
    chk(v[ECP_DCR_DIR], 1'b0);
    set_mode(ECP_M_BIDI);
    settle();
    chk({strobe_line, autofeed_line}, 2'h3);
    // ecp reverse: slow peripheral sends three bytes into the fifo
    wreg(ECP_OFS_DCR, 8'h20);
    rreg(ECP_OFS_DCR);
    chk(v[ECP_DCR_DIR], 1'b1);
    i_ecp_printer_model.dly = 7;
    for (int i = 0; i < 3; i++) begin
      b = 8'(rnd());
      i_ecp_printer_model.rev_q.push_back(b);
      exp_q.push_back({1'b0, b});
    end
    set_mode(ECP_M_ECP);
    for (k = 0; k < LIM; k++) begin
      // the last byte is pushed before the peripheral drops busy
      @(negedge clock);
      if (i_ecp_printer_model.rev_q.size() == 0 && busy_in === 1'b0) break;
    end
    chk(9'(k < LIM), 9'h1);
    chk(pd_oe, 1'b0);
    for (int i = 0; i < 3; i++) begin
      rreg(ECP_OFS_FIFO);
      chk(v, exp_q.pop_front());
    end
    // abort in mid-byte: host ack must drop at once
    i_ecp_printer_model.dly = 30;
    i_ecp_printer_model.rev_q.push_back(8'h5A);
    for (k = 0; k < LIM && busy_in !== 1'b1; k++) @(posedge clock);
    chk(9'(k < LIM), 9'h1);
    set_mode(ECP_M_BIDI);
    settle();
    chk(autofeed_line, 1'b1);
    wreg(ECP_OFS_DCR, 8'h00);
    set_mode(ECP_M_STD);
    rreg(ECP_OFS_XCR);
    chk(v[ECP_XCR_EMPTY], 1'b1);
    conclude();
  end
endmodule // ecp_parallel_port_mode_control_test
